// >>> src/snapshot_regs.svh
`ifndef SNAPSHOT_REGS_SVH
`define SNAPSHOT_REGS_SVH

// Register offsets
`define RANGE_CFG_OFS 8'h1D
`define RATE_PIN_OFS 8'h20

// Send-byte command codes
`define CMD_SNAP_RESET 8'h00
`define CMD_SNAP_GENERAL 8'h1E
`define CMD_SNAP_KEEP 8'h1F

// Reset values
`define RANGE_CFG_RST 16'h0000
`define RATE_EN_RST 4'h0

// Rate-pin register bit positions
`define RP_LEVEL_BIT 7
`define RP_RISE_SEEN_BIT 6
`define RP_FALL_SEEN_BIT 5
`define RP_EN_RST_RISE_BIT 4
`define RP_EN_KEEP_RISE_BIT 3
`define RP_EN_RST_FALL_BIT 2
`define RP_EN_KEEP_FALL_BIT 1

// Host settle time after a snapshot, and its cycle count at 25 MHz
`define CLK_PERIOD_NS 40
`define SNAP_SETTLE_NS 1000000
`define SNAP_SETTLE_CYC ((`SNAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> src/snapshot_pkg.sv
package snapshot_pkg;

	// Range codes for one sense channel
	typedef enum logic [1:0] {
		SENSE_UNI_100 = 2'h0,
		SENSE_BI_100 = 2'h1,
		SENSE_BI_50 = 2'h2,
		SENSE_RSVD = 2'h3
	} sense_range_t;

	// Actions handed to the accumulator datapath
	typedef struct packed {
		logic results_update;
		logic accum_clear;
		logic settings_latch;
	} snap_act_t;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Read answer
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} reg_rsp_t;

endpackage

// >>> src/snapshot_and_rate_pin_control.sv
// Functional notes
// - Low byte: four 2-bit bus range fields
// - Range register read/write, resets to zero
// - Snapshot commands are data-less send bytes
// - General-call snapshot copies results, clears accumulators
// - Keep snapshot copies results, keeps accumulators
// - Bit 7 shows present rate pin level
// - Bit 6 set on rise, cleared by reset-snapshots
// - Bit 5 set on fall, cleared by reset-snapshots
// - Bits 4..1 enable edge snapshots, never self-clear
// - Edge snapshot updates results; reset variant clears
// - Edge snapshots never activate pending settings
// - Reset variant beats keep variant on one edge
// - Rate register acts at once, no snapshot
// - Bit 0 ignores writes, reads zero
// - Pending range goes active on full snapshot
// - Selected pin high forces 8 SPS rate
`timescale 1ns/100ps
`include "snapshot_regs.svh"
`default_nettype none

module snapshot_and_rate_pin_control
	import snapshot_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire reg_req_t req,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic rate_pin,
	input wire logic rate_pin_select,
	output reg_rsp_t rsp_r,
	output snap_act_t act_r,
	output logic [15:0] active_range_r,
	output logic rate_override_r
);

	// Pending range settings, software view
	logic [15:0] range_pending_r;
	// Edge action enables, bits 4..1 of the rate register
	logic [3:0] rate_en_r;
	// Sticky edge flags
	logic rise_seen_flag_r;
	logic fall_seen_flag_r;
	// Synchroniser stages and edge history
	logic pin_meta_r;
	logic pin_sync_r;
	logic pin_prev_r;
	// Edge events, one cycle each
	logic rise_evt;
	logic fall_evt;
	// Decoded command strobes
	logic cmd_reset_snap;
	logic cmd_keep_snap;
	logic cmd_full;
	// Limited edge actions after priority
	logic lim_reset;
	logic lim_keep;
	// Merged action for this cycle
	snap_act_t act_nxt;
	// Read mux result
	logic [15:0] rd_nxt;

	// Two-stage synchroniser; only the second stage feeds logic
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= rate_pin;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// Edge detect on the clean copy, so one transition gives one event
	always_comb begin
		rise_evt = pin_sync_r & ~pin_prev_r;
		fall_evt = ~pin_sync_r & pin_prev_r;
	end

	// Command decode; codes arrive as bare send bytes with no data
	always_comb begin
		cmd_reset_snap = cmd_valid && (cmd_code == `CMD_SNAP_RESET || cmd_code == `CMD_SNAP_GENERAL);
		cmd_keep_snap = cmd_valid && (cmd_code == `CMD_SNAP_KEEP);
		cmd_full = cmd_reset_snap | cmd_keep_snap;
	end

	// Edge actions; reset variant masks keep variant for the same edge
	always_comb begin
		lim_reset = (rise_evt & rate_en_r[3]) | (fall_evt & rate_en_r[1]);
		lim_keep = ((rise_evt & rate_en_r[2] & ~rate_en_r[3])
			| (fall_evt & rate_en_r[0] & ~rate_en_r[1])) & ~lim_reset;
	end

	// Merge command and edge into one snapshot
	always_comb begin
		act_nxt.results_update = cmd_full | lim_reset | lim_keep;
		act_nxt.accum_clear = cmd_reset_snap | lim_reset;
		act_nxt.settings_latch = cmd_full;
	end

	// Snapshot strobes, one cycle wide
	always_ff @(posedge clk) begin
		if (reset) begin
			act_r <= '0;
		end else begin
			act_r <= act_nxt;
		end
	end

	// Pending range register; all sixteen bits writable
	always_ff @(posedge clk) begin
		if (reset) begin
			range_pending_r <= `RANGE_CFG_RST;
		end else if (req.wr && req.addr == `RANGE_CFG_OFS) begin
			range_pending_r <= req.wdata;
		end
	end

	// Active image; only full commands move pending into it
	always_ff @(posedge clk) begin
		if (reset) begin
			active_range_r <= `RANGE_CFG_RST;
		end else if (cmd_full) begin
			active_range_r <= range_pending_r;
		end
	end

	// Edge enables; write acts at once, bit 0 dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			rate_en_r <= `RATE_EN_RST;
		end else if (req.wr && req.addr == `RATE_PIN_OFS) begin
			rate_en_r <= req.wdata[`RP_EN_RST_RISE_BIT:`RP_EN_KEEP_FALL_BIT];
		end
	end

	// Rise flag; a rise in the clearing cycle still sets it
	always_ff @(posedge clk) begin
		if (reset) begin
			rise_seen_flag_r <= 1'b0;
		end else if (rise_evt) begin
			rise_seen_flag_r <= 1'b1;
		end else if (cmd_reset_snap) begin
			rise_seen_flag_r <= 1'b0;
		end
	end

	// Fall flag; keep-snapshots and edge snapshots never clear it
	always_ff @(posedge clk) begin
		if (reset) begin
			fall_seen_flag_r <= 1'b0;
		end else if (fall_evt) begin
			fall_seen_flag_r <= 1'b1;
		end else if (cmd_reset_snap) begin
			fall_seen_flag_r <= 1'b0;
		end
	end

	// Rate override follows the synced level when the pin has that job
	always_ff @(posedge clk) begin
		if (reset) begin
			rate_override_r <= 1'b0;
		end else begin
			rate_override_r <= pin_sync_r & rate_pin_select;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_nxt = 16'h0000;
		case (req.addr)
			`RANGE_CFG_OFS: begin
				rd_nxt = range_pending_r;
			end
			`RATE_PIN_OFS: begin
				rd_nxt[`RP_LEVEL_BIT] = pin_sync_r;
				rd_nxt[`RP_RISE_SEEN_BIT] = rise_seen_flag_r;
				rd_nxt[`RP_FALL_SEEN_BIT] = fall_seen_flag_r;
				rd_nxt[`RP_EN_RST_RISE_BIT:`RP_EN_KEEP_FALL_BIT] = rate_en_r;
				rd_nxt[0] = 1'b0;
			end
			default: begin
				rd_nxt = 16'h0000;
			end
		endcase
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_r <= '0;
		end else begin
			rsp_r.valid <= req.rd;
			rsp_r.data <= req.rd ? rd_nxt : 16'h0000;
		end
	end

	// Named steps for multi-step checks
	sequence seq_range_write;
		req.wr && req.addr == `RANGE_CFG_OFS;
	endsequence

	sequence seq_general_cmd;
		cmd_valid && cmd_code == `CMD_SNAP_GENERAL;
	endsequence

	sequence seq_keep_cmd_alone;
		cmd_valid && cmd_code == `CMD_SNAP_KEEP && !lim_reset;
	endsequence

	sequence seq_rise_both_enabled;
		rise_evt && rate_en_r[3] && rate_en_r[2];
	endsequence

	// Range write lands in the pending register next cycle
	AST_RANGE_WRITE: assert property (@(posedge clk) disable iff (reset)
		seq_range_write |=> range_pending_r == $past(req.wdata))
		else $error("range write not stored");

	// Reset leaves every range field at zero
	AST_RANGE_RESET: assert property (@(posedge clk)
		$past(reset) |-> range_pending_r == 16'h0000 && active_range_r == 16'h0000)
		else $error("range not zero after reset");

	// General call gives update, clear and latch together
	AST_GENERAL_SNAP: assert property (@(posedge clk) disable iff (reset)
		seq_general_cmd |=> act_r.results_update && act_r.accum_clear && act_r.settings_latch)
		else $error("general-call snapshot incomplete");

	// Keep snapshot without a reset-variant edge in the same cycle never clears accumulators
	AST_KEEP_SNAP: assert property (@(posedge clk) disable iff (reset)
		seq_keep_cmd_alone |=> act_r.results_update && !act_r.accum_clear)
		else $error("keep snapshot cleared accumulators");

	// Pin rise reaches the flag one edge after the edge event on the synced level
	AST_RISE_FLAG: assert property (@(posedge clk) disable iff (reset)
		rise_evt |=> rise_seen_flag_r)
		else $error("rise flag not set");

	// Fall sets its flag even against a clear
	AST_FALL_FLAG: assert property (@(posedge clk) disable iff (reset)
		fall_evt && cmd_reset_snap |=> fall_seen_flag_r)
		else $error("fall flag lost to clear");

	// Only reset-snapshots clear the rise flag
	AST_RISE_HOLD: assert property (@(posedge clk) disable iff (reset)
		rise_seen_flag_r && !cmd_reset_snap |=> rise_seen_flag_r)
		else $error("rise flag cleared wrongly");

	// Limited snapshot without command never latches settings
	AST_LIMITED_NO_LATCH: assert property (@(posedge clk) disable iff (reset)
		(lim_reset || lim_keep) && !cmd_valid |=> act_r.results_update && !act_r.settings_latch)
		else $error("edge snapshot latched settings");

	// Both enabled on a rise: reset variant only
	AST_PRIORITY: assert property (@(posedge clk) disable iff (reset)
		seq_rise_both_enabled |-> lim_reset && !lim_keep ##1 act_r.accum_clear)
		else $error("keep variant won over reset variant");

	// Active image takes pending value after a full command
	AST_ACTIVATE: assert property (@(posedge clk) disable iff (reset)
		cmd_full |=> active_range_r == $past(range_pending_r))
		else $error("pending range not activated");

	// Pending write alone does not touch the active image
	AST_PENDING_HOLD: assert property (@(posedge clk) disable iff (reset)
		!cmd_full |=> $stable(active_range_r))
		else $error("active range moved without command");

	// Bit 0 of the rate register always reads zero
	AST_BIT0_ZERO: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == `RATE_PIN_OFS |=> rsp_r.valid && !rsp_r.data[0])
		else $error("rate register bit 0 not zero");

	// Level bit tracks the synced pin
	AST_LEVEL_READ: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == `RATE_PIN_OFS |=> rsp_r.data[`RP_LEVEL_BIT] == $past(pin_sync_r))
		else $error("level bit wrong");

	// One event per transition
	AST_ONE_EVENT: assert property (@(posedge clk) disable iff (reset)
		rise_evt |=> !rise_evt && !fall_evt)
		else $error("double edge event");

	// Command and edge together take the stronger clear
	AST_MERGE: assert property (@(posedge clk) disable iff (reset)
		cmd_keep_snap && lim_reset |=> act_r.accum_clear && act_r.settings_latch)
		else $error("merged snapshot lost clear");

	// Override follows synced level one edge later when selected
	AST_OVERRIDE: assert property (@(posedge clk) disable iff (reset)
		pin_sync_r && rate_pin_select |=> rate_override_r)
		else $error("rate override missing");

	// Enables persist without a write
	AST_EN_STICKY: assert property (@(posedge clk) disable iff (reset)
		!(req.wr && req.addr == `RATE_PIN_OFS) |=> $stable(rate_en_r))
		else $error("edge enable changed by itself");

	// Only reset-snapshots clear the fall flag
	AST_FALL_HOLD: assert property (@(posedge clk) disable iff (reset)
		fall_seen_flag_r && !cmd_reset_snap |=> fall_seen_flag_r)
		else $error("fall flag cleared wrongly");

	// Reset-snapshot with no rise in that cycle clears the rise flag
	AST_RISE_CLEAR: assert property (@(posedge clk) disable iff (reset)
		cmd_reset_snap && !rise_evt |=> !rise_seen_flag_r)
		else $error("rise flag not cleared");

	// Both enabled on a fall: reset variant only
	AST_FALL_PRIORITY: assert property (@(posedge clk) disable iff (reset)
		fall_evt && rate_en_r[1] && rate_en_r[0] |-> lim_reset && !lim_keep)
		else $error("keep variant won on fall");

	// Limited keep snapshot updates results, leaves accumulators
	AST_LIMITED_KEEP: assert property (@(posedge clk) disable iff (reset)
		lim_keep && !cmd_valid |=> act_r.results_update && !act_r.accum_clear)
		else $error("limited keep cleared accumulators");

	// Enable write takes effect on the next edge, no snapshot needed
	AST_EN_WRITE: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == `RATE_PIN_OFS |=> rate_en_r == $past(req.wdata[`RP_EN_RST_RISE_BIT:`RP_EN_KEEP_FALL_BIT]))
		else $error("edge enable write not applied");

	// Upper byte of the rate register reads zero
	AST_RATE_UPPER: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == `RATE_PIN_OFS |=> rsp_r.data[15:8] == 8'h00)
		else $error("rate register upper byte not zero");

	// Without a full command nothing latches settings
	AST_NO_CMD_NO_LATCH: assert property (@(posedge clk) disable iff (reset)
		!cmd_full |=> !act_r.settings_latch)
		else $error("settings latched without command");

	// Reset leaves flags and enables clear
	AST_FLAG_RESET: assert property (@(posedge clk)
		$past(reset) |-> !rise_seen_flag_r && !fall_seen_flag_r && rate_en_r == 4'h0)
		else $error("flags or enables not zero after reset");

endmodule

`default_nettype wire

// >>> tb/snap_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the strobe port: register accesses and send-byte commands
module snap_host_model
	import snapshot_pkg::*;
#(
	parameter int SETTLE_CYC = 4 // Shortened wait before results are trusted
)
(
	input wire logic clk,
	input wire reg_rsp_t rsp,
	output reg_req_t req,
	output logic cmd_valid,
	output logic [7:0] cmd_code
);
	// Idle at time zero
	initial begin
		req = '0;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
	end

	// One write strobe; released fields show the inverse so nothing stale reads right
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// One read strobe; answer is registered, taken one cycle later
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
		#1;
		d = (rsp.valid === 1'b1) ? rsp.data : 16'hXXXX;
	endtask

	// Command code alone, no data byte, then the settle wait
	task automatic send_cmd(input logic [7:0] c);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		repeat (SETTLE_CYC) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// >>> tb/tb_snapshot_and_rate_pin_control.sv
`timescale 1ns/100ps
`include "snapshot_regs.svh"
`default_nettype none

module tb_snapshot_and_rate_pin_control;
	import snapshot_pkg::*;
	logic clk;
	logic reset;
	reg_req_t req;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic rate_pin;
	logic rate_pin_select;
	reg_rsp_t rsp_r;
	snap_act_t act_r;
	logic [15:0] active_range_r;
	logic rate_override_r;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_upd = 0; // Pulse counts, compared as deltas
	int n_clr = 0;
	int n_lat = 0;
	int u0, c0, l0;
	int seed;
	logic [15:0] rd, val, prev;
	logic [3:0] en;

	snapshot_and_rate_pin_control snapshot_and_rate_pin_control_i (.clk(clk), .reset(reset), .req(req),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rate_pin(rate_pin), .rate_pin_select(rate_pin_select),
		.rsp_r(rsp_r), .act_r(act_r), .active_range_r(active_range_r), .rate_override_r(rate_override_r));
	snap_host_model snap_host_model_i (.clk(clk), .rsp(rsp_r), .req(req), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Count action pulses and cut a hang short
	always @(posedge clk) begin
		n_upd += (act_r.results_update === 1'b1);
		n_clr += (act_r.accum_clear === 1'b1);
		n_lat += (act_r.settings_latch === 1'b1);
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", n, exp, seen);
			err_total++;
		end
	endtask

	// Pulses since the last call
	task automatic check_acts(input string n, input logic upd, input logic clr, input logic lat);
		check({n, " update"}, 16'(n_upd - u0), 16'(upd));
		check({n, " clear"}, 16'(n_clr - c0), 16'(clr));
		check({n, " latch"}, 16'(n_lat - l0), 16'(lat));
		u0 = n_upd;
		c0 = n_clr;
		l0 = n_lat;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string n);
		snap_host_model_i.read_reg(a, rd);
		check(n, rd, e);
	endtask

	// Expected rate-pin register image
	function automatic logic [15:0] rate_exp(input logic lvl, input logic rise, input logic fall, input logic [3:0] e);
		return {8'h00, lvl, rise, fall, e, 1'b0};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		seed = 89;
		prev = 16'h0000;
		reset = 1'b1;
		rate_pin = 1'b0;
		rate_pin_select = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		u0 = 0;
		c0 = 0;
		l0 = 0;
		rd_chk(`RANGE_CFG_OFS, 16'h0000, "range reset");
		rd_chk(`RATE_PIN_OFS, 16'h0000, "rate reset");
		$display("test reset done");
		// Pending range goes active only on a full snapshot; all three codes
		for (int i = 0; i < 4; i++) begin
			val = 16'($random(seed));
			snap_host_model_i.write_reg(`RANGE_CFG_OFS, val);
			rd_chk(`RANGE_CFG_OFS, val, "range readback");
			check("active held", active_range_r, prev);
			snap_host_model_i.send_cmd(i[0] ? `CMD_SNAP_KEEP : (i[1] ? `CMD_SNAP_GENERAL : `CMD_SNAP_RESET));
			check_acts("cmd", 1'b1, ~i[0], 1'b1);
			check("active", active_range_r, val);
			prev = val;
		end
		// Unknown code, unmapped write and read are refused
		snap_host_model_i.send_cmd(8'h55);
		check_acts("bad cmd", 1'b0, 1'b0, 1'b0);
		snap_host_model_i.write_reg(8'h21, 16'hFFFF);
		rd_chk(8'h21, 16'h0000, "unmapped");
		rd_chk(`RANGE_CFG_OFS, prev, "range kept");
		$display("test commands done");
		// Only bits 4..1 take a write, at once
		snap_host_model_i.write_reg(`RATE_PIN_OFS, 16'h00FF);
		rd_chk(`RATE_PIN_OFS, rate_exp(1'b0, 1'b0, 1'b0, 4'hF), "rate write");
		$display("test rate register done");
		// Pin edges with random enables; both variants enabled in the first pass, keep variants only in the second
		for (int i = 0; i < 6; i++) begin
			en = (i == 0) ? 4'hF : ((i == 1) ? 4'h5 : 4'($random(seed)));
			@(posedge clk);
			rate_pin_select <= 1'($random(seed));
			snap_host_model_i.write_reg(`RATE_PIN_OFS, {11'h000, en, 1'b0});
			snap_host_model_i.send_cmd(`CMD_SNAP_RESET);
			check_acts("flag clear", 1'b1, 1'b1, 1'b1);
			@(posedge clk);
			rate_pin <= 1'b1;
			repeat (8) @(posedge clk); // Covers the synchroniser lag with margin
			check_acts("rise", en[3] | en[2], en[3], 1'b0);
			check("override", 16'(rate_override_r), 16'(rate_pin_select));
			rd_chk(`RATE_PIN_OFS, rate_exp(1'b1, 1'b1, 1'b0, en), "after rise");
			@(posedge clk);
			rate_pin <= 1'b0;
			repeat (8) @(posedge clk);
			check_acts("fall", en[1] | en[0], en[1], 1'b0);
			rd_chk(`RATE_PIN_OFS, rate_exp(1'b0, 1'b1, 1'b1, en), "after fall");
		end
		// Keep snapshot leaves flags, general call clears them
		snap_host_model_i.send_cmd(`CMD_SNAP_KEEP);
		check_acts("keep", 1'b1, 1'b0, 1'b1);
		rd_chk(`RATE_PIN_OFS, rate_exp(1'b0, 1'b1, 1'b1, en), "flags kept");
		snap_host_model_i.send_cmd(`CMD_SNAP_GENERAL);
		check_acts("general", 1'b1, 1'b1, 1'b1);
		rd_chk(`RATE_PIN_OFS, rate_exp(1'b0, 1'b0, 1'b0, en), "flags cleared");
		$display("test pin edges done");
		// Command sampled in the same cycle as the synced edge: one merged snapshot
		snap_host_model_i.write_reg(`RATE_PIN_OFS, 16'h0010);
		@(posedge clk);
		rate_pin <= 1'b1;
		@(posedge clk);
		snap_host_model_i.send_cmd(`CMD_SNAP_KEEP);
		check_acts("merge rise", 1'b1, 1'b1, 1'b1);
		@(posedge clk);
		rate_pin <= 1'b0;
		@(posedge clk);
		snap_host_model_i.send_cmd(`CMD_SNAP_RESET);
		check_acts("merge fall", 1'b1, 1'b1, 1'b1);
		rd_chk(`RATE_PIN_OFS, rate_exp(1'b0, 1'b0, 1'b1, 4'h8), "fall beats clear");
		$display("test merge done");
		wrap_up();
	end
endmodule

`default_nettype wire
